// ---- src/cpld_macrocell_region.sv ----
// One logic block of 16 macrocells with its switch matrix, foldback bus,
// pin controls and keepers, joined to the global bus of the device.
// Assumes configuration is static while running and that the remote part
// of the global bus comes from logic on the same core clock.
`timescale 1ns/100ps
module cpld_macrocell_region (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset,
  // Static configuration
  input wire macrocell_pkg::mc_config_t [macrocell_pkg::REGION_MC-1:0] i_config,
  input wire logic [macrocell_pkg::MATRIX_OUTS-1:0][macrocell_pkg::GBUS_SEL_W-1:0] i_matrix_sel,
  // Device-wide nets from pins
  input wire logic i_global_clock_net,
  input wire logic i_global_clear_net,
  input wire logic [1:0] i_oe_pin,
  // Global bus from the other logic blocks
  input wire logic [macrocell_pkg::GBUS_REMOTE_W-1:0] i_remote_bus,
  // I/O pins of this block
  input wire macrocell_pkg::pin_sense_t [macrocell_pkg::REGION_MC-1:0] i_pin_sense,
  output macrocell_pkg::pin_drive_t [macrocell_pkg::REGION_MC-1:0] o_pin_drive,
  // Contributions to the global and regional interconnect
  output logic [macrocell_pkg::REGION_MC-1:0] o_pin_to_bus,
  output logic [macrocell_pkg::REGION_MC-1:0] o_feedback_to_bus,
  output logic [macrocell_pkg::REGION_MC-1:0] o_foldback_bus,
  output logic [macrocell_pkg::REGION_MC-1:0] o_state
);
  import macrocell_pkg::*;

  // Pin-side synchroniser
  logic [SYNC_STAGES_W-1:0] sync_meta_reg;
  logic [SYNC_STAGES_W-1:0] sync_reg;
  logic [SYNC_STAGES_W-1:0] sync_raw;
  logic [REGION_MC-1:0] raw_level;
  logic [REGION_MC-1:0] raw_undriven;

  // Synchronised pin views
  logic global_clock;
  logic global_clear;
  logic [1:0] oe_pin;
  logic [REGION_MC-1:0] pin_level;
  logic [REGION_MC-1:0] pin_undriven;

  // Keepers and reported pin levels
  logic [REGION_MC-1:0] keep_reg;
  logic [REGION_MC-1:0] keep_next;
  logic [REGION_MC-1:0] pin_report;

  // Interconnect
  logic [GBUS_W-1:0] global_bus;
  logic [MATRIX_OUTS-1:0] matrix_out;
  logic [REGION_MC-1:0] fold_bus;
  logic [REGION_MC-1:0] comb_out;
  logic [REGION_MC-1:0] q_out;
  logic [REGION_MC-1:0] feedback;
  logic [REGION_MC-1:0][PT_PER_MC-1:0] pt;

  genvar m;
  genvar p;
  genvar s;

  for (m = 0; m < REGION_MC; m++) begin : g_raw
    assign raw_level[m] = i_pin_sense[m].level;
    assign raw_undriven[m] = i_pin_sense[m].undriven;
  end

  assign sync_raw = {i_global_clock_net, i_global_clear_net, i_oe_pin, raw_level, raw_undriven};

  // Every pin input is asynchronous to the core clock
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      sync_meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      sync_meta_reg <= sync_raw;
      sync_reg <= sync_meta_reg;
    end
  end

  assign {global_clock, global_clear, oe_pin, pin_level, pin_undriven} = sync_reg;

  // Keeper remembers the last level seen while something drove the pin
  assign keep_next = (pin_level & ~pin_undriven) | (keep_reg & pin_undriven);

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      keep_reg <= {REGION_MC{KEEP_RESET}};
    end else begin
      keep_reg <= keep_next;
    end
  end

  for (m = 0; m < REGION_MC; m++) begin : g_report
    assign pin_report[m] = (i_config[m].keeper_on & pin_undriven[m]) ? keep_reg[m]
                         : pin_level[m];
  end

  // Remote signals, this block's pins and this block's buried feedback
  assign global_bus = {i_remote_bus, pin_report, feedback};

  for (s = 0; s < MATRIX_OUTS; s++) begin : g_matrix
    assign matrix_out[s] = bus_pick(global_bus, i_matrix_sel[s]);
  end

  for (m = 0; m < REGION_MC; m++) begin : g_mc
    mc_config_t cfg;
    logic [TERM_IN_W-1:0] term_in;
    logic fold_term;
    logic sum_term;
    logic store_data;
    logic elem_clk;
    logic clk_enable;
    logic clear;
    logic preset;
    logic pin_data;
    logic oe_pick;
    logic oe_final;

    assign cfg = i_config[m];
    assign term_in = {fold_bus, matrix_out};

    for (p = 0; p < PT_PER_MC; p++) begin : g_pt
      assign pt[m][p] = pt_eval(cfg.pt_true[p], cfg.pt_comp[p], term_in);
    end

    // Out-of-range selection falls back to the first term
    assign fold_term = (int'(cfg.fold_pt_sel) < PT_PER_MC) ? pt[m][cfg.fold_pt_sel]
                     : pt[m][0];
    assign fold_bus[m] = ~fold_term;

    // Own terms plus foldback terms widen one sum
    assign sum_term = (|(pt[m] & cfg.sum_pt_mask))
                    | (|(fold_bus & cfg.sum_fold_mask));
    assign comb_out[m] = sum_term ^ cfg.xor_invert;

    always_comb begin
      unique case (cfg.data_src)
        DATA_XOR: store_data = comb_out[m];
        DATA_PT: store_data = pt[m][PT_SEPARATE];
        DATA_PIN: store_data = pin_report[m];
        default: store_data = comb_out[m];
      endcase
    end

    assign elem_clk = (cfg.clk_src == CLK_GLOBAL) ? global_clock : pt[m][PT_CLOCK];

    // A term clock ignores the enable, so no term can gate its own edges
    assign clk_enable = (cfg.clk_src == CLK_GLOBAL && cfg.clk_en_on) ? pt[m][PT_CLK_EN]
                      : 1'h1;

    always_comb begin
      unique case (cfg.clear_src)
        CLR_OFF: clear = 1'h0;
        CLR_GLOBAL: clear = global_clear;
        CLR_PT: clear = pt[m][PT_CLEAR];
        CLR_BOTH: clear = global_clear | pt[m][PT_CLEAR];
      endcase
    end

    assign preset = (cfg.preset_src == PRE_PT) ? pt[m][PT_PRESET] : 1'h0;

    macrocell_storage u_storage (
      .i_core_clk(i_core_clk),
      .i_reset(i_reset),
      .i_mode(cfg.mode),
      .i_data(store_data),
      .i_second(pt[m][PT_SECOND_IN]),
      .i_elem_clk(elem_clk),
      .i_clk_enable(clk_enable),
      .i_clear(clear),
      .i_preset(preset),
      .o_q(q_out[m])
    );

    // Separate-term data forces a combinatorial pin and a registered feedback
    assign pin_data = (cfg.data_src == DATA_PT || cfg.pin_out_src == SRC_COMB) ? comb_out[m]
                    : q_out[m];
    // Feedback exists whatever the pin direction
    assign feedback[m] = (cfg.data_src == DATA_PT || cfg.feedback_src == SRC_REG) ? q_out[m]
                       : comb_out[m];

    always_comb begin
      unique case (cfg.oe_src)
        OE_PIN0: oe_pick = oe_pin[0];
        OE_PIN0_N: oe_pick = ~oe_pin[0];
        OE_PIN1: oe_pick = oe_pin[1];
        OE_PIN1_N: oe_pick = ~oe_pin[1];
        OE_IO_PIN: oe_pick = pin_report[cfg.oe_index];
        OE_IO_MC: oe_pick = comb_out[cfg.oe_index];
        default: oe_pick = 1'h0;
      endcase
    end

    always_comb begin
      unique case (cfg.pin_dir)
        DIR_IN: oe_final = 1'h0;
        DIR_OUT: oe_final = 1'h1;
        DIR_BIDIR: oe_final = oe_pick;
        default: oe_final = 1'h0;
      endcase
    end

    // Open collector only ever drives a low, so shared lines cannot fight
    assign o_pin_drive[m].out = cfg.open_collector ? 1'h0 : pin_data;
    assign o_pin_drive[m].oe = cfg.open_collector ? (oe_final & ~pin_data) : oe_final;
  end

  assign o_pin_to_bus = pin_report;
  assign o_feedback_to_bus = feedback;
  assign o_foldback_bus = fold_bus;
  assign o_state = q_out;

endmodule

// ---- src/macrocell_pkg.sv ----
// Package for the programmable-logic macrocell region: sizes, selector
// encodings, configuration and pin carriers, and shared decode functions.
// Assumes all users import it whole; no clock or reset lives here.
package macrocell_pkg;

  // Region and interconnect sizes
  localparam int REGION_MC = 16;
  localparam int TOTAL_MC = 128;
  localparam int TOTAL_PINS = 100;
  localparam int MATRIX_OUTS = 40;
  localparam int PT_PER_MC = 5;
  localparam int MAX_SUM_TERMS = 21;
  localparam int GBUS_W = TOTAL_PINS + TOTAL_MC;
  localparam int GBUS_REMOTE_W = GBUS_W - 2 * REGION_MC;
  localparam int GBUS_SEL_W = 8;
  localparam int TERM_IN_W = MATRIX_OUTS + REGION_MC;
  localparam int PT_SEL_W = 3;
  localparam int MC_IDX_W = 4;
  localparam int SYNC_STAGES_W = 4 + 2 * REGION_MC;

  // Fixed roles of the macrocell product terms
  localparam int PT_PRESET = 0;
  localparam int PT_CLEAR = 1;
  localparam int PT_CLK_EN = 2;
  localparam int PT_CLOCK = 3;
  localparam int PT_SEPARATE = 4;
  localparam int PT_SECOND_IN = 3;

  // Reset values
  localparam logic STATE_RESET = 1'h0;
  localparam logic KEEP_RESET = 1'h0;

  typedef enum logic [2:0] {MODE_D, MODE_T, MODE_JK, MODE_SR, MODE_LATCH} storage_mode_t;
  typedef enum logic [1:0] {DATA_XOR, DATA_PT, DATA_PIN} data_src_t;
  typedef enum logic {CLK_GLOBAL, CLK_PT} clk_src_t;
  typedef enum logic [1:0] {CLR_OFF, CLR_GLOBAL, CLR_PT, CLR_BOTH} clear_src_t;
  typedef enum logic {PRE_OFF, PRE_PT} preset_src_t;
  typedef enum logic {SRC_REG, SRC_COMB} out_src_t;
  typedef enum logic [1:0] {DIR_IN, DIR_OUT, DIR_BIDIR} pin_dir_t;
  typedef enum logic [2:0] {
    OE_PIN0, OE_PIN0_N, OE_PIN1, OE_PIN1_N, OE_IO_PIN, OE_IO_MC
  } oe_src_t;

  typedef struct packed {
    logic [PT_PER_MC-1:0][TERM_IN_W-1:0] pt_true;
    logic [PT_PER_MC-1:0][TERM_IN_W-1:0] pt_comp;
    logic [PT_PER_MC-1:0] sum_pt_mask;
    logic [REGION_MC-1:0] sum_fold_mask;
    logic xor_invert;
    logic [PT_SEL_W-1:0] fold_pt_sel;
    storage_mode_t mode;
    data_src_t data_src;
    clk_src_t clk_src;
    logic clk_en_on;
    clear_src_t clear_src;
    preset_src_t preset_src;
    out_src_t pin_out_src;
    out_src_t feedback_src;
    pin_dir_t pin_dir;
    oe_src_t oe_src;
    logic [MC_IDX_W-1:0] oe_index;
    logic open_collector;
    logic keeper_on;
  } mc_config_t;

  typedef struct packed {
    logic level;
    logic undriven;
  } pin_sense_t;

  typedef struct packed {
    logic out;
    logic oe;
  } pin_drive_t;

  // Product term: AND of chosen true and complemented inputs; empty is high
  function automatic logic pt_eval(input logic [TERM_IN_W-1:0] true_mask,
                                   input logic [TERM_IN_W-1:0] comp_mask,
                                   input logic [TERM_IN_W-1:0] term_in);
    pt_eval = &((~true_mask | term_in) & (~comp_mask | ~term_in));
  endfunction

  // Global bus pick; codes past the bus width read low
  function automatic logic bus_pick(input logic [GBUS_W-1:0] bus,
                                    input logic [GBUS_SEL_W-1:0] sel);
    bus_pick = (int'(sel) < GBUS_W) ? bus[sel] : 1'h0;
  endfunction

endpackage

// ---- src/macrocell_storage.sv ----
// Configurable storage element of one macrocell: D, T, JK, SR or latch.
// Assumes its element clock is a level already on the core clock domain.
`timescale 1ns/100ps
module macrocell_storage (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset,
  // Configuration
  input wire macrocell_pkg::storage_mode_t i_mode,
  // Element controls
  input wire logic i_data,
  input wire logic i_second,
  input wire logic i_elem_clk,
  input wire logic i_clk_enable,
  input wire logic i_clear,
  input wire logic i_preset,
  // State
  output logic o_q
);
  import macrocell_pkg::*;

  logic q_reg;
  logic q_next;
  logic clk_prev_reg;
  logic rise;
  logic edge_value;
  logic store_value;

  assign rise = i_elem_clk & ~clk_prev_reg;

  always_comb begin
    unique case (i_mode)
      MODE_D: edge_value = i_data;
      MODE_T: edge_value = q_reg ^ i_data;
      MODE_JK: edge_value = (i_data & ~q_reg) | (~i_second & q_reg);
      MODE_SR: edge_value = ~i_second & (i_data | q_reg);
      default: edge_value = i_data;
    endcase
  end

  // Latch follows while the clock is high; others move on gated rising edges
  assign store_value = (i_mode == MODE_LATCH) ? (i_elem_clk ? i_data : q_reg)
                     : ((rise & i_clk_enable) ? edge_value : q_reg);

  // Clear wins over preset, both override any clocked value
  assign q_next = i_clear ? 1'h0 : (i_preset ? 1'h1 : store_value);

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      q_reg <= STATE_RESET;
      clk_prev_reg <= 1'h0;
    end else begin
      q_reg <= q_next;
      clk_prev_reg <= i_elem_clk;
    end
  end

  // Asynchronous controls show at the output without waiting for a clock
  assign o_q = i_clear ? 1'h0 : (i_preset ? 1'h1 : q_reg);

endmodule

// ---- tb/pad_model.sv ----
// Pad model: resolves each pin from the region's drive and a far driver.
// Assumes no pull resistors, so a released pin drifts away from its level.
`timescale 1ns/100ps
module pad_model (
  // Drivers
  input wire macrocell_pkg::pin_drive_t [15:0] i_drive,
  input wire logic [15:0] i_ext_en,
  input wire logic [15:0] i_ext_val,
  // Resolved pads
  output macrocell_pkg::pin_sense_t [15:0] o_sense
);
  import macrocell_pkg::*;
  logic [15:0] last = 16'h0;
  always @* begin
    for (int i = 0; i < 16; i++) begin
      o_sense[i].undriven = !(i_drive[i].oe || i_ext_en[i]);
      if (i_drive[i].oe) last[i] = i_drive[i].out;
      else if (i_ext_en[i]) last[i] = i_ext_val[i];
      o_sense[i].level = o_sense[i].undriven ? !last[i] : last[i];
    end
  end
endmodule

// ---- tb/region_checker.sv ----
// Checker on cell 0 of the region: storage timing, pin drive, keeper.
// Assumes the bench exercises cell 0; other cells go unwatched.
`timescale 1ns/100ps
module region_checker (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire macrocell_pkg::mc_config_t [15:0] i_config,
  input wire logic i_global_clock_net,
  input wire logic i_global_clear_net,
  input wire logic [1:0] i_oe_pin,
  input wire macrocell_pkg::pin_sense_t [15:0] i_pin_sense,
  input wire macrocell_pkg::pin_drive_t [15:0] o_pin_drive,
  input wire logic [15:0] o_pin_to_bus,
  input wire logic [15:0] o_feedback_to_bus,
  input wire logic [15:0] o_state
);
  import macrocell_pkg::*;
  mc_config_t c;
  logic q, fb, po, oe, quiet;
  assign c = i_config[0];
  assign q = o_state[0];
  assign fb = o_feedback_to_bus[0];
  assign po = o_pin_drive[0].out;
  assign oe = o_pin_drive[0].oe;
  // No async override, so the state only moves on element edges
  assign quiet = c.clk_src == CLK_GLOBAL && c.clear_src == CLR_OFF && c.preset_src == PRE_OFF;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  sequence clr_held;
    (i_global_clear_net && c.clear_src inside {CLR_GLOBAL, CLR_BOTH})[*3];
  endsequence
  sequence clk_low;
    (!i_global_clock_net && quiet && c.mode != MODE_LATCH)[*5];
  endsequence
  clear_wins_a: assert property (clr_held |-> !q)
    else $error("state not cleared");
  edge_only_a: assert property (clk_low |-> $stable(q))
    else $error("state moved without edge");
  // Registered feedback must hold while data moves and no edge comes
  fb_reg_a: assert property ((quiet && c.feedback_src == SRC_REG && c.mode != MODE_LATCH
      && !i_global_clock_net)[*5] |-> $stable(fb)) else $error("feedback not registered");
  pin_reg_a: assert property (quiet && !c.open_collector && c.data_src != DATA_PT
      && c.pin_out_src == SRC_REG |-> po == q) else $error("pin not registered");
  dir_in_a: assert property (c.pin_dir == DIR_IN |-> !oe)
    else $error("input pin driven");
  oe_inv_a: assert property ((c.pin_dir == DIR_BIDIR && c.oe_src == OE_PIN0_N
      && !c.open_collector && !i_oe_pin[0])[*3] |-> oe) else $error("enable not inverted");
  oc_low_a: assert property (c.open_collector |-> !po)
    else $error("open collector drove high");
  keep_a: assert property ((c.keeper_on && i_pin_sense[0].undriven)[*4]
      |-> $stable(o_pin_to_bus[0])) else $error("kept level moved");
endmodule

bind cpld_macrocell_region region_checker chk_u (.i_core_clk(i_core_clk), .i_reset(i_reset),
  .i_config(i_config), .i_global_clock_net(i_global_clock_net),
  .i_global_clear_net(i_global_clear_net), .i_oe_pin(i_oe_pin), .i_pin_sense(i_pin_sense),
  .o_pin_drive(o_pin_drive), .o_pin_to_bus(o_pin_to_bus),
  .o_feedback_to_bus(o_feedback_to_bus), .o_state(o_state));

// ---- tb/tb.sv ----
// Bench for the macrocell region: walks cell 0 through its modes.
// Assumes cells 1-15 stay unconfigured inputs.
`timescale 1ns/100ps
module tb;
  import macrocell_pkg::*;
  localparam logic [5:0] OE_TAB = 6'h16;
  logic clk, rst, global_clock_net, gclr;
  logic [1:0] oep;
  logic [GBUS_REMOTE_W-1:0] rb;
  logic [15:0] xe, xv, pbus, fbus, fold, st;
  logic [MATRIX_OUTS-1:0][GBUS_SEL_W-1:0] msel;
  mc_config_t [15:0] cfg;
  pin_sense_t [15:0] sense;
  pin_drive_t [15:0] drv;
  mc_config_t b;
  int mismatches, checks;
  cpld_macrocell_region dut_u (.i_core_clk(clk), .i_reset(rst), .i_config(cfg),
    .i_matrix_sel(msel), .i_global_clock_net(global_clock_net), .i_global_clear_net(gclr),
    .i_oe_pin(oep), .i_remote_bus(rb), .i_pin_sense(sense), .o_pin_drive(drv),
    .o_pin_to_bus(pbus), .o_feedback_to_bus(fbus), .o_foldback_bus(fold), .o_state(st));
  pad_model pm_u (.i_drive(drv), .i_ext_en(xe), .i_ext_val(xv), .o_sense(sense));
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic cmp(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Term t reads remote bit t; the sum is term 4 alone
  task automatic fresh;
    b = '0;
    for (int t = 0; t < PT_PER_MC; t++) b.pt_true[t][t] = 1'h1;
    b.sum_pt_mask = 5'h10;
    b.pin_dir = DIR_OUT;
  endtask
  task automatic set;
    @(posedge clk) cfg[0] <= b;
    tick(3);
  endtask
  task automatic rise(input logic v);
    @(posedge clk) global_clock_net <= v;
    tick(4);
  endtask
  task automatic put(input logic v);
    @(posedge clk) rb[4] <= v;
    tick(6);
  endtask
  task automatic hit(input logic [2:0] m);
    @(posedge clk) {gclr, rb[1:0]} <= m;
    tick(4);
    @(posedge clk) {gclr, rb[1:0]} <= 3'h0;
    tick(4);
  endtask
  task automatic step(input logic [1:0] jk, input logic exp);
    @(posedge clk) rb[4:3] <= jk;
    rise(1'h0);
    rise(1'h1);
    cmp(st[0], exp);
  endtask
  task automatic t_dflop;
    fresh;
    set;
    put(1'h1);
    cmp(st[0], 1'h0);
    rise(1'h1);
    cmp(st[0], 1'h1);
    put(1'h0);
    rise(1'h0);
    cmp(st[0], 1'h1);
    $display("dflop done");
  endtask
  task automatic t_enable;
    fresh;
    b.clk_en_on = 1'h1;
    set;
    rise(1'h1);
    cmp(st[0], 1'h1);
    @(posedge clk) rb[2] <= 1'h1;
    rise(1'h0);
    rise(1'h1);
    cmp(st[0], 1'h0);
    b.clk_src = CLK_PT;
    set;
    @(posedge clk) rb[4:2] <= 3'b100;
    tick(4);
    @(posedge clk) rb[3] <= 1'h1;
    tick(4);
    cmp(st[0], 1'h1);
    $display("enable done");
  endtask
  task automatic t_modes;
    fresh;
    b.mode = MODE_SR;
    set;
    step(2'b11, 1'h0);
    step(2'b10, 1'h1);
    b.mode = MODE_JK;
    set;
    step(2'b11, 1'h0);
    step(2'b10, 1'h1);
    b.mode = MODE_T;
    set;
    step(2'b10, 1'h0);
    step(2'b00, 1'h0);
    $display("modes done");
  endtask
  task automatic t_latch;
    fresh;
    b.mode = MODE_LATCH;
    set;
    put(1'h1);
    cmp(st[0], 1'h1);
    put(1'h0);
    cmp(st[0], 1'h0);
    rise(1'h0);
    put(1'h1);
    cmp(st[0], 1'h0);
    $display("latch done");
  endtask
  task automatic t_clear;
    fresh;
    b.preset_src = PRE_PT;
    for (int s = 0; s < 4; s++) begin
      b.clear_src = clear_src_t'(s);
      set;
      for (int w = 0; w < 2; w++) begin
        hit(3'b001);
        cmp(st[0], 1'h1);
        hit(w ? 3'b010 : 3'b100);
        cmp(st[0], !s[w]);
      end
    end
    hit(3'b101);
    cmp(st[0], 1'h0);
    $display("clear done");
  endtask
  task automatic t_pins;
    fresh;
    b.preset_src = PRE_PT;
    b.clear_src = CLR_GLOBAL;
    set;
    put(1'h0);
    hit(3'b001);
    cmp(drv[0].out, 1'h1);
    cmp(fbus[0], 1'h1);
    cmp(fold[0], 1'h1);
    b.pin_out_src = SRC_COMB;
    b.feedback_src = SRC_COMB;
    set;
    cmp(drv[0].out, 1'h0);
    cmp(fbus[0], 1'h0);
    b.pin_out_src = SRC_REG;
    b.data_src = DATA_PT;
    set;
    cmp(drv[0].out, 1'h0);
    cmp(fbus[0], 1'h1);
    b.data_src = DATA_XOR;
    b.pin_dir = DIR_BIDIR;
    b.oe_index = 4'h1;
    @(posedge clk) {oep, xe[1], xv[1]} <= 4'b1011;
    for (int s = 0; s < 6; s++) begin
      b.oe_src = oe_src_t'(s);
      set;
      cmp(drv[0].oe, OE_TAB[s]);
    end
    cmp(pbus[1], 1'h1);
    b.pin_dir = DIR_IN;
    set;
    cmp(drv[0].oe, 1'h0);
    b.pin_dir = DIR_OUT;
    b.open_collector = 1'h1;
    set;
    cmp(drv[0].oe, 1'h0);
    hit(3'b100);
    cmp(drv[0].oe, 1'h1);
    cmp(drv[0].out, 1'h0);
    $display("pins done");
  endtask
  task automatic t_keep;
    fresh;
    b.pin_dir = DIR_IN;
    b.keeper_on = 1'h1;
    set;
    @(posedge clk) {xe[0], xv[0]} <= 2'b11;
    tick(4);
    @(posedge clk) xe[0] <= 1'h0;
    tick(6);
    cmp(pbus[0], 1'h1);
    b.keeper_on = 1'h0;
    set;
    cmp(pbus[0], 1'h0);
    $display("keep done");
  endtask
  // Sum from own foldback only, inverted back by the XOR; then pin data
  task automatic t_fold;
    fresh;
    b.sum_pt_mask = 5'h0;
    b.sum_fold_mask = 16'h0001;
    b.fold_pt_sel = 3'h4;
    b.xor_invert = 1'h1;
    b.pin_out_src = SRC_COMB;
    set;
    put(1'h1);
    cmp(drv[0].out, 1'h1);
    cmp(fold[0], 1'h0);
    put(1'h0);
    cmp(drv[0].out, 1'h0);
    b.data_src = DATA_PIN;
    b.pin_dir = DIR_IN;
    set;
    @(posedge clk) {xe[0], xv[0]} <= 2'b11;
    tick(4);
    rise(1'h1);
    cmp(st[0], 1'h1);
    cmp(fbus[0], 1'h1);
    // Term 0 now reads this cell's own feedback off the global bus
    @(posedge clk) msel[0] <= 8'h00;
    b.fold_pt_sel = 3'h0;
    set;
    cmp(fold[0], 1'h0);
    $display("fold done");
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Run takes about 500 cycles; the limit leaves wide margin
  initial begin
    #100000;
    mismatches++;
    tally_and_finish;
  end
  initial begin
    {global_clock_net, gclr, oep, rb, xe, xv} = '0;
    rst = 1'h1;
    cfg = '0;
    for (int k = 0; k < MATRIX_OUTS; k++) msel[k] = GBUS_SEL_W'(2 * REGION_MC + k);
    repeat (5) @(posedge clk);
    rst <= 1'h0;
    tick(2);
    t_dflop;
    t_enable;
    t_modes;
    t_latch;
    t_clear;
    t_pins;
    t_keep;
    t_fold;
    tally_and_finish;
  end
endmodule
